// ==== avm_cfg.svh ====
// Offsets, field positions, reset values and counts of the violation monitor
`ifndef AVM_CFG_SVH
`define AVM_CFG_SVH

`define AVM_ID_W        4
`define AVM_MAX_OUT     4'h8
`define AVM_STAT_W      14
`define AVM_LINK_RST_MIN 16

`define AVM_B_AWV_RST   0
`define AVM_B_ARV_RST   1
`define AVM_B_WV_RST    2
`define AVM_B_RV_RST    3
`define AVM_B_BV_RST    4
`define AVM_B_AWR_RST   5
`define AVM_B_WR_RST    6
`define AVM_B_BR_RST    7
`define AVM_B_ARR_RST   8
`define AVM_B_RR_RST    9
`define AVM_B_RID       10
`define AVM_B_BID       11
`define AVM_B_RD_OVF    12
`define AVM_B_WR_OVF    13
`define AVM_RST_CHK_MSK 14'h03FF

`define AVM_OFF_FLAG    12'h000
`define AVM_OFF_CUR     12'h100
`define AVM_OFF_SNAP    12'h200
`define AVM_OFF_CTRL    12'h300

`define AVM_CTRL_SREN   0
`define AVM_CTRL_SEV_LO 1
`define AVM_CTRL_SEV_HI 2
`define AVM_CTRL_STOP   3
`define AVM_CTRL_RST    4'h0

`endif

// ==== avm_pkg.sv ====
// Types shared by the violation monitor and its tracker
package avm_pkg;
  typedef enum logic [1:0] {AVM_SEV_INFO, AVM_SEV_WARN, AVM_SEV_ERR} avm_sev_e;
  typedef logic [3:0] avm_cnt_t;
  typedef struct packed {
    avm_cnt_t [15:0] cnt;
  } avm_trk_s;
endpackage

// ==== avm_trk_if.sv ====
// Carrier between the monitor and one per-ID outstanding tracker
`timescale 1ns/1ps
`default_nettype none
interface avm_trk_if;
  logic       clr;
  logic       push;
  logic [3:0] push_id;
  logic       pop;
  logic [3:0] pop_id;
  logic       pop_miss;
  logic       push_full;
  modport mon (output clr, push, push_id, pop, pop_id, input pop_miss, push_full);
  modport trk (input clr, push, push_id, pop, pop_id, output pop_miss, push_full);
endinterface
`default_nettype wire

// ==== avm_trk.sv ====
// Per-ID count of outstanding transactions on one direction of the link
`timescale 1ns/1ps
`default_nettype none
`include "avm_cfg.svh"
module avm_trk (
  input wire logic mclk,
  input wire logic rst_n,
  avm_trk_if.trk   tk
);
  avm_pkg::avm_trk_s r;
  avm_pkg::avm_trk_s n;

  assign tk.pop_miss  = tk.pop && (r.cnt[tk.pop_id] == 4'h0);
  assign tk.push_full = tk.push && (r.cnt[tk.push_id] == `AVM_MAX_OUT);

  // Each ID keeps its own depth; an entry lives until its completion pops it
  always_comb
  begin
    n = r;
    if (tk.clr)
    begin
      n = '0;
    end
    else
    begin
      if (tk.push && !tk.push_full)
      begin
        n.cnt[tk.push_id] = n.cnt[tk.push_id] + 4'h1;
      end
      if (tk.pop && !tk.pop_miss)
      begin
        n.cnt[tk.pop_id] = n.cnt[tk.pop_id] - 4'h1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      r <= '0;
    else
      r <= n;
  end

  cnt_bound_a: assert property (@(posedge mclk) disable iff (!rst_n)
    tk.push && !tk.clr && !tk.pop && (r.cnt[tk.push_id] < `AVM_MAX_OUT)
    |=> r.cnt[$past(tk.push_id)] == $past(r.cnt[tk.push_id]) + 4'h1)
    else $error("tracker count did not advance");
endmodule
`default_nettype wire

// ==== avm_mon.sv ====
// Passive link violation monitor with reset tracking and status readout
// Function
// - Link is observed on the same clock as master and slave.
// - Register readout port runs on that same clock.
// - Link reset and status-clear reset are active low, sampled on mclk.
// - Either reset clears the status vector and the summary flag.
// - Status-clear reset clears status but not link view or tracking.
// - With status-clear enabled, check valid and ready levels after link reset.
// - Reset-related flags are cleared by the status-clear reset too.
// - Status-clear disabled omits the ten valid and ready reset checks.
// - Reads tracked by read-address ID, writes by write-address ID.
// - Per-ID entries held until completion; depth is max outstanding per ID.
// - Each cycle with new violations, except a cycle that clears status, pulses viol_pulse with the lowest new bit index and the severity.
// - Reported bit index names exactly the status bit that was set.
// - Severity is info, warning or error; error with stop enabled raises viol_stop.
// - Every check result stays a separate named net.
// - Snapshot of status taken when summary flag first rises, held.
// - Snapshot cleared by either reset.
//
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "avm_cfg.svh"
module avm_mon (
  input  wire logic                   mclk,
  input  wire logic                   rst_n,
  input  wire logic                   link_rst_n,
  input  wire logic                   sys_rst_n,
  input  wire logic                   aw_valid,
  input  wire logic                   aw_ready,
  input  wire logic [`AVM_ID_W-1:0]   aw_id,
  input  wire logic                   w_valid,
  input  wire logic                   w_ready,
  input  wire logic                   b_valid,
  input  wire logic                   b_ready,
  input  wire logic [`AVM_ID_W-1:0]   b_id,
  input  wire logic                   ar_valid,
  input  wire logic                   ar_ready,
  input  wire logic [`AVM_ID_W-1:0]   ar_id,
  input  wire logic                   r_valid,
  input  wire logic                   r_ready,
  input  wire logic [`AVM_ID_W-1:0]   r_id,
  input  wire logic                   r_last,
  input  wire logic [11:0]            reg_addr,
  input  wire logic [31:0]            reg_wdata,
  input  wire logic                   reg_we,
  input  wire logic                   reg_re,
  output logic      [31:0]            reg_rdata,
  output logic      [`AVM_STAT_W-1:0] violation_status_vector,
  output logic                        violation_summary_flag,
  output logic                        viol_pulse,
  output logic      [3:0]             viol_bit,
  output avm_pkg::avm_sev_e           viol_sev,
  output logic                        viol_stop
);

  typedef struct packed {
    logic [`AVM_STAT_W-1:0] status;
    logic                   flag;
    logic [`AVM_STAT_W-1:0] snap;
    logic                   in_rst;
    logic                   sr_en;
    avm_pkg::avm_sev_e      sev;
    logic                   stop_en;
    logic [31:0]            rdata;
    logic                   pulse;
    logic [3:0]             bitn;
  } avm_mon_s;

  avm_mon_s r;
  avm_mon_s n;

  avm_trk_if rd_if ();
  avm_trk_if wr_if ();

  ////////////////////////////////////////////////////////////////////////////
  // Lowest set bit; the message index must point at one real status bit
  function automatic logic [3:0] avm_low_bit(input logic [`AVM_STAT_W-1:0] v);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = `AVM_STAT_W - 1; i >= 0; i--)
    begin
      if (v[i])
        idx = 4'(i);
    end
    return idx;
  endfunction

  function automatic logic [31:0] avm_zx(input logic [`AVM_STAT_W-1:0] v);
    return {{(32 - `AVM_STAT_W){1'b0}}, v};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Link view and per-ID tracking, all on mclk
  logic link_ok;
  logic post_rst;
  logic sr_chk;
  logic stat_clr;

  assign link_ok  = link_rst_n;
  assign post_rst = r.in_rst && link_rst_n;
  assign sr_chk   = r.sr_en && post_rst;
  // Status-clear reset touches status and snapshot only, never the trackers
  assign stat_clr = !link_rst_n || (r.sr_en && !sys_rst_n);

  assign rd_if.clr     = !link_rst_n;
  assign rd_if.push    = ar_valid && ar_ready;
  assign rd_if.push_id = ar_id;
  assign rd_if.pop     = r_valid && r_ready && r_last;
  assign rd_if.pop_id  = r_id;

  assign wr_if.clr     = !link_rst_n;
  assign wr_if.push    = aw_valid && aw_ready;
  assign wr_if.push_id = aw_id;
  assign wr_if.pop     = b_valid && b_ready;
  assign wr_if.pop_id  = b_id;

  avm_trk u_rd_trk (
    .mclk  (mclk),
    .rst_n (rst_n),
    .tk    (rd_if.trk)
  );

  avm_trk u_wr_trk (
    .mclk  (mclk),
    .rst_n (rst_n),
    .tk    (wr_if.trk)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Individual checks, kept as separate nets for debug probing
  logic chk_wr_addr_valid_after_reset;
  logic chk_rd_addr_valid_after_reset;
  logic chk_wr_data_valid_after_reset;
  logic chk_rd_data_valid_after_reset;
  logic chk_wr_resp_valid_after_reset;
  logic chk_wr_addr_ready_after_reset;
  logic chk_wr_data_ready_after_reset;
  logic chk_wr_resp_ready_after_reset;
  logic chk_rd_addr_ready_after_reset;
  logic chk_rd_data_ready_after_reset;
  logic chk_read_id_matches_outstanding;
  logic chk_resp_id_matches_outstanding;
  logic chk_rd_outstanding_overflow;
  logic chk_wr_outstanding_overflow;
  logic [`AVM_STAT_W-1:0] chk_vec;
  logic [`AVM_STAT_W-1:0] chk_new;

  // First cycle out of link reset: every valid and ready must be low
  assign chk_wr_addr_valid_after_reset = sr_chk && aw_valid;
  assign chk_rd_addr_valid_after_reset = sr_chk && ar_valid;
  assign chk_wr_data_valid_after_reset = sr_chk && w_valid;
  assign chk_rd_data_valid_after_reset = sr_chk && r_valid;
  assign chk_wr_resp_valid_after_reset = sr_chk && b_valid;
  assign chk_wr_addr_ready_after_reset = sr_chk && aw_ready;
  assign chk_wr_data_ready_after_reset = sr_chk && w_ready;
  assign chk_wr_resp_ready_after_reset = sr_chk && b_ready;
  assign chk_rd_addr_ready_after_reset = sr_chk && ar_ready;
  assign chk_rd_data_ready_after_reset = sr_chk && r_ready;
  assign chk_read_id_matches_outstanding = link_ok && rd_if.pop_miss;
  assign chk_resp_id_matches_outstanding = link_ok && wr_if.pop_miss;
  assign chk_rd_outstanding_overflow = link_ok && rd_if.push_full;
  assign chk_wr_outstanding_overflow = link_ok && wr_if.push_full;

  // Fixed bit map: a reported index always names one check net
  always_comb
  begin
    chk_vec = '0;
    chk_vec[`AVM_B_AWV_RST] = chk_wr_addr_valid_after_reset;
    chk_vec[`AVM_B_ARV_RST] = chk_rd_addr_valid_after_reset;
    chk_vec[`AVM_B_WV_RST]  = chk_wr_data_valid_after_reset;
    chk_vec[`AVM_B_RV_RST]  = chk_rd_data_valid_after_reset;
    chk_vec[`AVM_B_BV_RST]  = chk_wr_resp_valid_after_reset;
    chk_vec[`AVM_B_AWR_RST] = chk_wr_addr_ready_after_reset;
    chk_vec[`AVM_B_WR_RST]  = chk_wr_data_ready_after_reset;
    chk_vec[`AVM_B_BR_RST]  = chk_wr_resp_ready_after_reset;
    chk_vec[`AVM_B_ARR_RST] = chk_rd_addr_ready_after_reset;
    chk_vec[`AVM_B_RR_RST]  = chk_rd_data_ready_after_reset;
    chk_vec[`AVM_B_RID]     = chk_read_id_matches_outstanding;
    chk_vec[`AVM_B_BID]     = chk_resp_id_matches_outstanding;
    chk_vec[`AVM_B_RD_OVF]  = chk_rd_outstanding_overflow;
    chk_vec[`AVM_B_WR_OVF]  = chk_wr_outstanding_overflow;
  end

  assign chk_new = chk_vec & ~r.status;

  ////////////////////////////////////////////////////////////////////////////
  // Status, snapshot, report and register port
  always_comb
  begin
    n = r;
    n.in_rst = !link_rst_n;
    n.pulse = 1'b0;
    n.rdata = 32'h0000_0000;
    if (stat_clr)
    begin
      n.status = '0;
      n.snap = '0;
    end
    else
    begin
      n.status = r.status | chk_vec;
      // Report only the lowest newly set bit; other bits new in the same cycle get no report
      if (|chk_new)
      begin
        n.pulse = 1'b1;
        n.bitn = avm_low_bit(chk_new);
      end
      if (!r.flag && (|n.status))
        n.snap = n.status;
    end
    n.flag = |n.status;
    if (reg_we && (reg_addr == `AVM_OFF_CTRL))
    begin
      n.sr_en = reg_wdata[`AVM_CTRL_SREN];
      n.stop_en = reg_wdata[`AVM_CTRL_STOP];
      case (reg_wdata[`AVM_CTRL_SEV_HI:`AVM_CTRL_SEV_LO])
        2'h0:    n.sev = avm_pkg::AVM_SEV_INFO;
        2'h1:    n.sev = avm_pkg::AVM_SEV_WARN;
        default: n.sev = avm_pkg::AVM_SEV_ERR;
      endcase
    end
    // Read data reflects state before this cycle's update
    if (reg_re)
    begin
      case (reg_addr)
        `AVM_OFF_FLAG: n.rdata = {31'h0000_0000, r.flag};
        `AVM_OFF_CUR:  n.rdata = avm_zx(r.status);
        `AVM_OFF_SNAP: n.rdata = avm_zx(r.snap);
        `AVM_OFF_CTRL: n.rdata = {28'h000_0000, r.stop_en, r.sev, r.sr_en};
        default:       n.rdata = 32'h0000_0000;
      endcase
    end
  end

  // House reset is the only async one; link and status-clear resets act on edges
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      r <= '0;
    else
      r <= n;
  end

  assign violation_status_vector = r.status;
  assign violation_summary_flag  = r.flag;
  assign viol_pulse = r.pulse;
  assign viol_bit   = r.bitn;
  assign viol_sev   = r.sev;
  assign viol_stop  = r.pulse && r.stop_en && (r.sev == avm_pkg::AVM_SEV_ERR);
  assign reg_rdata  = r.rdata;

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the monitor's own behaviour
  link_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !link_rst_n |=> (r.status == '0) && !r.flag && (r.snap == '0))
    else $error("link reset left status set");

  sys_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
    r.sr_en && !sys_rst_n |=> (r.status == '0) && !r.flag)
    else $error("status-clear reset left status set");

  sys_keeps_trk_a: assert property (@(posedge mclk) disable iff (!rst_n)
    link_rst_n && !sys_rst_n |-> !rd_if.clr && !wr_if.clr)
    else $error("status-clear reset touched tracking");

  omit_chk_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !r.sr_en |-> (chk_vec & `AVM_RST_CHK_MSK) == '0)
    else $error("reset check active while disabled");

  aw_after_rst_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(link_rst_n) && r.sr_en && sys_rst_n && aw_valid ##1 link_rst_n && sys_rst_n
    |-> r.status[`AVM_B_AWV_RST])
    else $error("valid after reset not flagged");

  rid_miss_a: assert property (@(posedge mclk) disable iff (!rst_n)
    chk_read_id_matches_outstanding && !stat_clr |=> r.status[`AVM_B_RID] && r.flag)
    else $error("unmatched read id not flagged");

  snap_first_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(r.flag) |-> r.snap == r.status)
    else $error("snapshot not taken at first flag");

  snap_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    r.flag && !stat_clr |=> $stable(r.snap))
    else $error("snapshot changed while held");

  pulse_bit_a: assert property (@(posedge mclk) disable iff (!rst_n)
    r.pulse |-> r.status[r.bitn] && ((($past(r.status) >> r.bitn) & 14'h0001) == 14'h0000))
    else $error("reported bit not newly set");

  flag_track_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (r.status != '0) == r.flag)
    else $error("summary flag out of step with status");

  // Clearing, reporting and readout; read tracker counts are also compared here with their past value
  trk_kept_a: assert property (@(posedge mclk) disable iff (!rst_n)
    link_rst_n && !sys_rst_n && !rd_if.push && !rd_if.pop |=> $stable(u_rd_trk.r))
    else $error("status-clear reset changed read tracking");

  snap_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
    stat_clr |=> (r.snap == '0))
    else $error("snapshot survived a clearing reset");

  rst_bits_clr_a: assert property (@(posedge mclk) disable iff (!rst_n)
    r.sr_en && !sys_rst_n |=> ((r.status & `AVM_RST_CHK_MSK) == '0))
    else $error("reset check bits survived status-clear");

  pulse_new_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (|chk_new) && !stat_clr |=> r.pulse)
    else $error("new violation not reported");

  bit_lowest_a: assert property (@(posedge mclk) disable iff (!rst_n)
    r.pulse |-> ((r.status & ~$past(r.status) & ((14'h0001 << r.bitn) - 14'h0001)) == '0))
    else $error("reported bit is not the lowest new bit");

  rdy_after_rst_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(link_rst_n) && r.sr_en && sys_rst_n && r_ready |=> r.status[`AVM_B_RR_RST])
    else $error("ready after reset not flagged");

  wr_ovf_a: assert property (@(posedge mclk) disable iff (!rst_n)
    chk_wr_outstanding_overflow && !stat_clr |=> r.status[`AVM_B_WR_OVF])
    else $error("write overflow not flagged");

  rdata_idle_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !$past(reg_re) |-> (r.rdata == 32'h0000_0000))
    else $error("read data shown without a read");

  snap_idle_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !r.flag |-> (r.snap == '0))
    else $error("snapshot set while flag low");

endmodule
`default_nettype wire

// ==== avm_link_model.sv ====
// Behavioural master and slave on the monitored link
`timescale 1ns/1ps
`default_nettype none
module avm_link_model (
  input  wire logic       mclk,
  output logic      [4:0] vld,
  output logic      [4:0] rdy,
  output logic      [3:0] id,
  output logic            last
);
  // Lane order: 0 aw, 1 w, 2 b, 3 ar, 4 r; one shared 4-bit ID bus
  initial
  begin
    vld  = 5'h00;
    rdy  = 5'h00;
    id   = 4'h0;
    last = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One handshake, ready after lag cycles; both sides run on mclk
  task automatic beat(input int ch, input logic [3:0] bid, input int lag);
    @(posedge mclk);
    vld[ch] <= 1'b1;
    id      <= bid;
    last    <= (ch == 4);
    repeat (lag) @(posedge mclk);
    rdy[ch] <= 1'b1;
    @(posedge mclk);
    vld  <= 5'h00;
    rdy  <= 5'h00;
    // Released ID lines must not keep the old value
    id   <= ~bid;
    last <= 1'b0;
  endtask

  task automatic lvl(input logic [4:0] v, input logic [4:0] r);
    vld <= v;
    rdy <= r;
  endtask
endmodule
`default_nettype wire

// ==== avm_mon_bench.sv ====
// Self-checking bench for the link violation monitor
`timescale 1ns/1ps
`default_nettype none
module avm_mon_bench;
  logic              mclk;
  logic              rst_n;
  logic              link_rst_n;
  logic              sys_rst_n;
  logic [11:0]       reg_addr;
  logic [31:0]       reg_wdata;
  logic              reg_we;
  logic              reg_re;
  logic [31:0]       reg_rdata;
  logic [13:0]       stat;
  logic              flag;
  logic              pulse;
  logic [3:0]        vbit;
  avm_pkg::avm_sev_e sev;
  logic              stop;
  logic [4:0]        vld;
  logic [4:0]        rdy;
  logic [3:0]        id;
  logic              last;
  int                n_errors;
  int                checked;
  int                cyc;

  avm_link_model i_avm_link_model (.mclk(mclk), .vld(vld), .rdy(rdy), .id(id), .last(last));
  avm_mon i_avm_mon (
    .mclk(mclk), .rst_n(rst_n), .link_rst_n(link_rst_n), .sys_rst_n(sys_rst_n),
    .aw_valid(vld[0]), .aw_ready(rdy[0]), .aw_id(id), .w_valid(vld[1]), .w_ready(rdy[1]),
    .b_valid(vld[2]), .b_ready(rdy[2]), .b_id(id), .ar_valid(vld[3]), .ar_ready(rdy[3]),
    .ar_id(id), .r_valid(vld[4]), .r_ready(rdy[4]), .r_id(id), .r_last(last),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata(reg_rdata), .violation_status_vector(stat), .violation_summary_flag(flag),
    .viol_pulse(pulse), .viol_bit(vbit), .viol_sev(sev), .viol_stop(stop));

  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    if (n_errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Whole run needs well under a thousand cycles
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_errors++;
      end_of_test;
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_we    <= 1'b1;
    @(posedge mclk);
    reg_we    <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm);
    @(posedge mclk);
    reg_addr <= a;
    reg_re   <= 1'b1;
    @(posedge mclk);
    reg_re   <= 1'b0;
    #1;
    chk(nm, e, reg_rdata);
  endtask

  // Status, flag, pulse and bit index one step after an edge
  task automatic seen(input logic [13:0] s, input logic p, input logic [3:0] b);
    #1;
    chk("status", 32'(s), 32'(stat));
    chk("flag", 32'(|s), 32'(flag));
    chk("pulse", 32'(p), 32'(pulse));
    if (p)
      chk("bit", 32'(b), 32'(vbit));
  endtask

  task automatic sclr;
    @(posedge mclk);
    sys_rst_n <= 1'b0;
    @(posedge mclk);
    sys_rst_n <= 1'b1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rd(12'h000, 32'h0, "flag reg");
    rd(12'h100, 32'h0, "current");
    rd(12'h200, 32'h0, "snapshot");
    rd(12'h300, 32'h0, "control");
    rd(12'h004, 32'h0, "unmapped");
    @(posedge mclk);
    #1;
    chk("idle rdata", 32'h0, reg_rdata);
    wr(12'h100, 32'hFFFFFFFF);
    rd(12'h100, 32'h0, "current");
    wr(12'h300, 32'h6);
    rd(12'h300, 32'h4, "control");
  endtask

  task automatic t_track;
    i_avm_link_model.beat(4, 4'h5, 0);
    seen(14'h0400, 1'b1, 4'hA);
    rd(12'h200, 32'h400, "snapshot");
    i_avm_link_model.beat(3, 4'h3, 2);
    i_avm_link_model.beat(4, 4'h3, 1);
    seen(14'h0400, 1'b0, 4'h0);
    i_avm_link_model.beat(0, 4'h2, 1);
    i_avm_link_model.beat(2, 4'h2, 0);
    seen(14'h0400, 1'b0, 4'h0);
    i_avm_link_model.beat(2, 4'h2, 0);
    seen(14'h0C00, 1'b1, 4'hB);
    rd(12'h200, 32'h400, "snapshot");
    rd(12'h000, 32'h1, "flag reg");
  endtask

  task automatic t_sev;
    wr(12'h300, 32'hC);
    for (int k = 0; k < 9; k++)
      i_avm_link_model.beat(3, 4'h7, k % 2);
    seen(14'h1C00, 1'b1, 4'hC);
    chk("sev", 32'(avm_pkg::AVM_SEV_ERR), 32'(sev));
    chk("stop", 32'h1, 32'(stop));
    wr(12'h300, 32'h2);
    for (int k = 0; k < 9; k++)
      i_avm_link_model.beat(0, 4'h1, 0);
    seen(14'h3C00, 1'b1, 4'hD);
    chk("sev", 32'(avm_pkg::AVM_SEV_WARN), 32'(sev));
    chk("stop", 32'h0, 32'(stop));
  endtask

  task automatic t_sys;
    wr(12'h300, 32'h1);
    i_avm_link_model.beat(3, 4'h4, 0);
    sclr;
    seen(14'h0000, 1'b0, 4'h0);
    rd(12'h200, 32'h0, "snapshot");
    i_avm_link_model.beat(4, 4'h4, 0);
    seen(14'h0000, 1'b0, 4'h0);
    i_avm_link_model.beat(4, 4'h4, 0);
    seen(14'h0400, 1'b1, 4'hA);
    wr(12'h300, 32'h0);
    sclr;
    seen(14'h0400, 1'b0, 4'h0);
  endtask

  task automatic t_rstchk(input logic en, input logic [4:0] v, input logic [4:0] r,
                          input logic [13:0] e, input logic [3:0] b);
    wr(12'h300, 32'(en));
    @(posedge mclk);
    link_rst_n <= 1'b0;
    repeat (16) @(posedge mclk);
    link_rst_n <= 1'b1;
    i_avm_link_model.lvl(v, r);
    @(posedge mclk);
    i_avm_link_model.lvl(5'h00, 5'h00);
    // Pulse stands only in the cycle after the offending one
    seen(e, |e, b);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst_n      = 1'b0;
    link_rst_n = 1'b0;
    sys_rst_n  = 1'b1;
    reg_addr   = 12'h000;
    reg_wdata  = 32'h0;
    reg_we     = 1'b0;
    reg_re     = 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (14) @(posedge mclk);
    link_rst_n <= 1'b1;
    t_regs;
    t_track;
    t_sev;
    t_sys;
    t_rstchk(1'b1, 5'h1F, 5'h00, 14'h001F, 4'h0);
    sclr;
    seen(14'h0000, 1'b0, 4'h0);
    t_rstchk(1'b1, 5'h00, 5'h1F, 14'h03E0, 4'h5);
    @(posedge mclk);
    rst_n <= 1'b0;
    seen(14'h0000, 1'b0, 4'h0);
    @(posedge mclk);
    rst_n <= 1'b1;
    rd(12'h300, 32'h0, "control");
    t_rstchk(1'b0, 5'h1F, 5'h00, 14'h0000, 4'h0);
    end_of_test;
  end
endmodule
`default_nettype wire
